// ### design/pmrs_pkg.sv
/*
  Constants, register map and mode type of the power mode and reset sequencer.
  Assumes one clock (mclk_i, the oscillator clock) and a plain register port.
*/
package pmrs_pkg;

  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 16;
  localparam int NUM_PERIPH = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] INTEGRATION_CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STOP_DISABLE_OFS        = 4'h1;
  localparam logic [ADDR_W-1:0] POWER_CONFIG_OFS        = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_OFS              = 4'h3;

  // control register fields
  localparam int CTRL_SW_RESET_BIT = 0;

  // power configuration fields
  localparam int PWR_SRC_SEL_BIT  = 0;
  localparam int PWR_PLL_PD_BIT   = 1;
  localparam int PWR_RELAXATION_OSCILLATOR_SB_BIT  = 2;
  localparam int PWR_LREG_SB_BIT  = 3;
  localparam int PWR_RELAXATION_OSCILLATOR_PD_BIT  = 4;
  localparam int PWR_EXT_CLK_BIT  = 5;
  localparam int PWR_HS_SEL_BIT   = 6;
  localparam int PWR_W            = 7;
  localparam logic [PWR_W-1:0] PWR_RESET_VAL = 7'h00;
  localparam logic [NUM_PERIPH-1:0] SD_RESET_VAL = 8'h00;

  // status register fields
  localparam int STAT_MODE_LSB   = 0;
  localparam int STAT_STANDBY    = 2;
  localparam int STAT_CLOCK_GENERATOR_RESET = 3;
  localparam int STAT_PERIPH_RST = 4;
  localparam int STAT_CORE_RST   = 5;

  // reset sequence counts
  localparam int POR_EXT_CYC  = 64;
  localparam int CLKGEN_CYC   = 32;
  localparam int PERIPH_CYC   = 32;
  localparam int CORE_CYC     = 32;
  localparam int SYNC_RST_CYC = 3;
  localparam int WDOG_DIV     = 1024;
  localparam int WDOG_W       = 10;

  // clock rates
  localparam longint MCLK_HZ        = 20_000_000;
  localparam longint SYS_CLK_MAX_HZ = 32_000_000;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP,
    MODE_POWER_DOWN
  } pmrs_mode_t;

endpackage

// ### design/pmrs_sync3.sv
/*
  Three-stage synchroniser with agreement filter.
  Assumes an asynchronous input; output changes once stages two and three agree.
*/
`timescale 1ns/1ps
module pmrs_sync3 (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  // data
  input  wire logic async_i,
  input  wire logic reset_val_i,
  output logic      sync_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else if (ce_i)
    begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // reset value taken after release, never under the async reset
  logic primed;
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      primed <= 1'b0;
      sync_o <= 1'b0;
    end
    else if (ce_i)
    begin
      primed <= 1'b1;
      if (!primed)
        sync_o <= reset_val_i;
      else if (s2 == s3)
        sync_o <= s3;
    end
  end
endmodule

// ### design/pmrs_rst_stage.sv
/*
  One reset extension stage: released N ticks after its hold input falls.
  Assumes hold and tick come from logic on mclk_i.
*/
`timescale 1ns/1ps
module pmrs_rst_stage #(
  parameter int N   = 32,
  parameter int CW  = 7
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  // control
  input  wire logic hold_i,
  input  wire logic tick_i,
  output logic      done_o
);
  localparam logic [CW-1:0] LAST = CW'(N - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt    <= '0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (hold_i)
      begin
        cnt    <= '0;
        done_o <= 1'b0;
      end
      else if (tick_i && !done_o)
      begin
        if (cnt == LAST)
          done_o <= 1'b1;
        else
          cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// ### design/pmrs_top.sv
/*
  Power mode control and staged reset sequencing.
  Assumes mclk_i is the oscillator clock, reset_n_i the raw power-on reset,
  core and peripheral inputs on mclk_i, the reset pin and the external
  standby clock asynchronous.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module pmrs_top
  import pmrs_pkg::*;
(
  // clock and reset
  input  wire logic                           mclk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           ce_i,
  // register port
  input  wire logic [pmrs_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [pmrs_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [pmrs_pkg::DATA_W-1:0]    rdata_o,
  // reset sources
  input  wire logic                           ext_reset_n_i,
  input  wire logic                           watchdog_timeout_reset_i,
  input  wire logic                           watchdog_loss_of_reference_reset_i,
  // core events
  input  wire logic                           wait_instr_i,
  input  wire logic                           stop_instr_i,
  input  wire logic                           irq_any_i,
  input  wire logic [pmrs_pkg::NUM_PERIPH-1:0] irq_periph_i,
  input  wire logic                           low_voltage_irq_i,
  input  wire logic                           debug_entry_i,
  input  wire logic                           ext_standby_clk_i,
  // clock enables
  output logic                                master_clk_en_o,
  output logic                                core_clk_en_o,
  output logic                                mem_clk_en_o,
  output logic      [pmrs_pkg::NUM_PERIPH-1:0] periph_clk_en_o,
  output logic                                hs_clk_en_o,
  output logic                                watchdog_tick_o,
  // power configuration
  output logic                                relaxation_source_select_o,
  output logic                                pll_power_down_o,
  output logic                                relaxation_osc_standby_o,
  output logic                                large_regulator_standby_o,
  output logic                                relaxation_osc_power_down_o,
  // staged resets, active high
  output logic                                jtag_reset_o,
  output logic                                sync_reset_o,
  output logic                                clock_generator_reset_o,
  output logic                                peripheral_reset_o,
  output logic                                core_reset_o
);
  import pmrs_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                  ext_rst_n_s;
  logic                  ext_clk_s;
  logic                  ext_clk_q;
  logic                  ext_por_done;
  logic                  sync_done;
  logic                  clkgen_done;
  logic                  periph_done;
  logic                  core_done;
  logic                  sw_reset;
  logic                  combined_rst;
  logic                  sys_tick;
  logic                  sys_div;
  logic                  ext_div;
  logic [WDOG_W-1:0]     wdog_cnt;
  logic [NUM_PERIPH-1:0] stop_disable_controls;
  logic [PWR_W-1:0]      pwr_cfg;
  logic                  standby;
  logic                  pll_selected;
  logic                  stop_wake;
  pmrs_mode_t            mode;
  pmrs_mode_t            next_mode;

  // ------------------------------------------------------------
  // asynchronous inputs
  // ------------------------------------------------------------
  pmrs_sync3 u_sync_ext_rst (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .async_i     (ext_reset_n_i),
    .reset_val_i (1'b0),
    .sync_o      (ext_rst_n_s)
  );

  pmrs_sync3 u_sync_ext_clk (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .async_i     (ext_standby_clk_i),
    .reset_val_i (1'b0),
    .sync_o      (ext_clk_s)
  );

  // ------------------------------------------------------------
  // reset combination
  // ------------------------------------------------------------
  // pin and power-on are async; software and watchdog already on mclk_i
  // in power-down only pin or power-on recovers
  always_comb
  begin
    combined_rst = !ext_por_done || !ext_rst_n_s;
    if (mode != MODE_POWER_DOWN)
      combined_rst = combined_rst || sw_reset || watchdog_timeout_reset_i
                     || watchdog_loss_of_reference_reset_i;
  end

  // ------------------------------------------------------------
  // reset extension stages
  // ------------------------------------------------------------
  // power-on, sync and clock generator stages count mclk_i cycles; peripheral and core stages count sys_tick
  pmrs_rst_stage #(.N(POR_EXT_CYC), .CW(7)) u_por_ext (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .hold_i    (1'b0),
    .tick_i    (1'b1),
    .done_o    (ext_por_done)
  );

  pmrs_rst_stage #(.N(SYNC_RST_CYC), .CW(2)) u_sync_rst (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .hold_i    (combined_rst),
    .tick_i    (1'b1),
    .done_o    (sync_done)
  );

  pmrs_rst_stage #(.N(CLKGEN_CYC), .CW(6)) u_clock_generator_reset (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .hold_i    (combined_rst),
    .tick_i    (1'b1),
    .done_o    (clkgen_done)
  );

  pmrs_rst_stage #(.N(PERIPH_CYC), .CW(6)) u_periph_rst (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .hold_i    (combined_rst || !clkgen_done),
    .tick_i    (sys_tick),
    .done_o    (periph_done)
  );

  pmrs_rst_stage #(.N(CORE_CYC), .CW(6)) u_core_rst (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .hold_i    (combined_rst || !periph_done),
    .tick_i    (sys_tick),
    .done_o    (core_done)
  );

  // ------------------------------------------------------------
  // reset outputs: clock generator, peripheral and core released on the falling edge, jtag and sync on the rising edge
  // ------------------------------------------------------------
  always_ff @(negedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      clock_generator_reset_o <= 1'b1;
    else if (ce_i)
      clock_generator_reset_o <= !clkgen_done;
  end

  always_ff @(negedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      peripheral_reset_o <= 1'b1;
      core_reset_o       <= 1'b1;
    end
    else if (ce_i)
    begin
      peripheral_reset_o <= !periph_done;
      core_reset_o       <= !core_done;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      jtag_reset_o <= 1'b1;
      sync_reset_o <= 1'b1;
    end
    else if (ce_i)
    begin
      jtag_reset_o <= 1'b0;
      sync_reset_o <= !sync_done;
    end
  end

  // ------------------------------------------------------------
  // system clock tick
  // ------------------------------------------------------------
  // master/2 normally; in standby with external clock, every second edge
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sys_div   <= 1'b0;
      ext_div   <= 1'b0;
      ext_clk_q <= 1'b0;
      sys_tick  <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_clk_q <= ext_clk_s;
      sys_div   <= !sys_div;
      if (standby && pwr_cfg[PWR_EXT_CLK_BIT])
      begin
        if (ext_clk_s && !ext_clk_q)
          ext_div <= !ext_div;
        sys_tick <= ext_clk_s && !ext_clk_q && ext_div;
      end
      else
        sys_tick <= sys_div;
    end
  end

  // ------------------------------------------------------------
  // watchdog tick
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wdog_cnt        <= '0;
      watchdog_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wdog_cnt        <= wdog_cnt + 1'b1;
      watchdog_tick_o <= (wdog_cnt == WDOG_W'(WDOG_DIV - 1));
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stop_disable_controls <= SD_RESET_VAL;
      pwr_cfg               <= PWR_RESET_VAL;
    end
    else if (ce_i)
    begin
      if (clock_generator_reset_o)
      begin
        stop_disable_controls <= SD_RESET_VAL;
        pwr_cfg               <= PWR_RESET_VAL;
      end
      else if (wr_i)
      begin
        if (addr_i == STOP_DISABLE_OFS)
          stop_disable_controls <= wdata_i[NUM_PERIPH-1:0];
        if (addr_i == POWER_CONFIG_OFS)
          pwr_cfg <= wdata_i[PWR_W-1:0];
      end
    end
  end

  // software reset: one-cycle pulse, its logic held by the sync reset
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      sw_reset <= 1'b0;
    else if (ce_i)
    begin
      if (!sync_done)
        sw_reset <= 1'b0;
      else
        sw_reset <= wr_i && (addr_i == INTEGRATION_CONTROL_OFS)
                    && wdata_i[CTRL_SW_RESET_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= '0;
    else if (ce_i)
    begin
      rdata_o <= '0;
      if (rd_i)
      begin
        unique case (addr_i)
          STOP_DISABLE_OFS: rdata_o <= DATA_W'(stop_disable_controls);
          POWER_CONFIG_OFS: rdata_o <= DATA_W'(pwr_cfg);
          STATUS_OFS:
          begin
            rdata_o[STAT_MODE_LSB +: 2] <= mode;
            rdata_o[STAT_STANDBY]       <= standby;
            rdata_o[STAT_CLOCK_GENERATOR_RESET]    <= clock_generator_reset_o;
            rdata_o[STAT_PERIPH_RST]    <= peripheral_reset_o;
            rdata_o[STAT_CORE_RST]      <= core_reset_o;
          end
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // power configuration outputs
  // ------------------------------------------------------------
  assign standby      = pwr_cfg[PWR_SRC_SEL_BIT] && pwr_cfg[PWR_PLL_PD_BIT]
                        && pwr_cfg[PWR_RELAXATION_OSCILLATOR_SB_BIT] && pwr_cfg[PWR_LREG_SB_BIT];
  assign pll_selected = !pwr_cfg[PWR_SRC_SEL_BIT] && !pwr_cfg[PWR_PLL_PD_BIT];

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      relaxation_source_select_o  <= 1'b0;
      pll_power_down_o            <= 1'b0;
      relaxation_osc_standby_o    <= 1'b0;
      large_regulator_standby_o   <= 1'b0;
      relaxation_osc_power_down_o <= 1'b0;
    end
    else if (ce_i)
    begin
      relaxation_source_select_o  <= pwr_cfg[PWR_SRC_SEL_BIT];
      pll_power_down_o            <= pwr_cfg[PWR_PLL_PD_BIT];
      relaxation_osc_standby_o    <= pwr_cfg[PWR_RELAXATION_OSCILLATOR_SB_BIT];
      large_regulator_standby_o   <= pwr_cfg[PWR_LREG_SB_BIT];
      relaxation_osc_power_down_o <= pwr_cfg[PWR_RELAXATION_OSCILLATOR_PD_BIT]
                                     && standby;
    end
  end

  // ------------------------------------------------------------
  // power mode state machine
  // ------------------------------------------------------------
  assign stop_wake = |(irq_periph_i & stop_disable_controls)
                     || low_voltage_irq_i || debug_entry_i;

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN:
      begin
        if (standby && pwr_cfg[PWR_RELAXATION_OSCILLATOR_PD_BIT])
          next_mode = MODE_POWER_DOWN;
        else if (stop_instr_i)
          next_mode = MODE_STOP;
        else if (wait_instr_i)
          next_mode = MODE_WAIT;
      end
      MODE_WAIT:
        if (irq_any_i || debug_entry_i)
          next_mode = MODE_RUN;
      MODE_STOP:
        if (stop_wake)
          next_mode = MODE_RUN;
      MODE_POWER_DOWN:
        next_mode = MODE_POWER_DOWN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mode <= MODE_RUN;
    else if (ce_i)
    begin
      if (combined_rst || core_reset_o)
        mode <= MODE_RUN;
      else
        mode <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // clock gating
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      master_clk_en_o <= 1'b0;
      core_clk_en_o   <= 1'b0;
      mem_clk_en_o    <= 1'b0;
      periph_clk_en_o <= '0;
      hs_clk_en_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      master_clk_en_o <= !clock_generator_reset_o
                         && (mode != MODE_POWER_DOWN);
      core_clk_en_o   <= sys_tick && (mode == MODE_RUN);
      mem_clk_en_o    <= sys_tick && (mode == MODE_RUN);
      for (int i = 0; i < NUM_PERIPH; i++)
        periph_clk_en_o[i] <= sys_tick
          && ((mode == MODE_RUN) || (mode == MODE_WAIT)
              || ((mode == MODE_STOP) && stop_disable_controls[i]));
      hs_clk_en_o     <= pll_selected && pwr_cfg[PWR_HS_SEL_BIT]
                         && ((mode == MODE_RUN) || (mode == MODE_WAIT));
    end
  end
endmodule

// ### dv/pmrs_monitor.sv
/* Checker bound to pmrs_top: reset staging, clock gating, watchdog tick.
   Assumes ce_i high and wake inputs quiet around wait and stop. */
`timescale 1ns/1ps
module pmrs_monitor (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic wait_instr_i,
  input wire logic stop_instr_i,
  input wire logic master_clk_en_o,
  input wire logic core_clk_en_o,
  input wire logic mem_clk_en_o,
  input wire logic watchdog_tick_o,
  input wire logic relaxation_osc_power_down_o,
  input wire logic jtag_reset_o,
  input wire logic sync_reset_o,
  input wire logic clock_generator_reset_o,
  input wire logic peripheral_reset_o,
  input wire logic core_reset_o
);
  logic [9:0] wd_cnt;
  logic       wd_seen;
  default clocking mon_cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // cycles since last tick, armed only once clocks run
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      wd_cnt  <= 10'h000;
      wd_seen <= 1'b0;
    end
    else if (ce_i)
    begin
      wd_cnt  <= watchdog_tick_o ? 10'h000 : wd_cnt + 10'h001;
      wd_seen <= !clock_generator_reset_o && (wd_seen || watchdog_tick_o);
    end
  a_jtag_por_only: assert property ($past(reset_n_i) |-> !jtag_reset_o)
    else $error("test logic reset outside power-on");
  a_clkgen_count: assert property ($fell(sync_reset_o) |->
    ##[24:32] ($fell(clock_generator_reset_o) || sync_reset_o)) else $error("clkgen release");
  a_periph_count: assert property ($fell(clock_generator_reset_o) |->
    ##[60:68] ($fell(peripheral_reset_o) || clock_generator_reset_o)) else $error("periph");
  a_core_count: assert property ($fell(peripheral_reset_o) |->
    ##[60:68] ($fell(core_reset_o) || clock_generator_reset_o)) else $error("core release");
  a_stages_follow: assert property (clock_generator_reset_o && $past(clock_generator_reset_o) |->
    peripheral_reset_o && core_reset_o) else $error("stage not held");
  a_wdog_period: assert property (watchdog_tick_o && wd_seen && ce_i |-> wd_cnt == 10'h3FF)
    else $error("watchdog tick spacing");
  a_wait_gating: assert property (wait_instr_i && !stop_instr_i && !core_reset_o |->
    ##3 !(core_clk_en_o || mem_clk_en_o)) else $error("core clock in wait");
  a_stop_gating: assert property (stop_instr_i && !core_reset_o && !relaxation_osc_power_down_o |->
    ##3 (master_clk_en_o && !core_clk_en_o)) else $error("stop gating");
endmodule
bind pmrs_top pmrs_monitor i_monitor (.*);

// ### dv/pmrs_core_model.sv
/* Core stand-in: issues wait and stop instructions, runs the standby clock.
   Assumes requests from the bench on mclk_i. */
`timescale 1ns/1ps
module pmrs_core_model (
  // clock and requests
  input  wire logic       mclk_i,
  input  wire logic       core_reset_i,
  input  wire logic [1:0] req_i,
  // toward the sequencer
  output logic            wait_instr_o,
  output logic            stop_instr_o,
  output logic            ext_standby_clk_o
);
  // no instruction while the core is held in reset
  always_ff @(posedge mclk_i)
  begin
    wait_instr_o <= (req_i == 2'd1) && !core_reset_i;
    stop_instr_o <= (req_i == 2'd2) && !core_reset_i;
  end
  initial
  begin
    ext_standby_clk_o = 1'b0;
    forever #1250 ext_standby_clk_o = ~ext_standby_clk_o;
  end
endmodule

// ### dv/pmrs_top_test.sv
/* Bench for pmrs_top with a reference of mode and registers.
   Assumes pmrs_monitor bound and pmrs_core_model as the core. */
`timescale 1ns/1ps
module pmrs_top_test;
  import pmrs_pkg::*;
  logic mclk_i, reset_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, cc;
  logic ext_reset_n_i = 1'b1, irq_any_i = 1'b0, low_voltage_irq_i = 1'b0, debug_entry_i = 1'b0;
  logic wd_to = 1'b0, wd_lor = 1'b0, wait_instr_i, stop_instr_i, ext_standby_clk_i;
  logic master_clk_en_o, core_clk_en_o, mem_clk_en_o, hs_clk_en_o, watchdog_tick_o;
  logic jtag_reset_o, sync_reset_o, clock_generator_reset_o, peripheral_reset_o, core_reset_o;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, rnd = 16'hEB54;
  logic [7:0]  irq_periph_i = 8'h00, periph_clk_en_o, m_sd, pe;
  logic [6:0]  m_pwr;
  logic [4:0]  po;
  logic [1:0]  req = 2'd0;
  int          n_errors = 0, tests_run = 0, m_mode = 0, n;
  pmrs_top i_dut (.*, .watchdog_timeout_reset_i(wd_to), .watchdog_loss_of_reference_reset_i(wd_lor),
    .relaxation_source_select_o(po[0]), .pll_power_down_o(po[1]),
    .relaxation_osc_standby_o(po[2]), .large_regulator_standby_o(po[3]),
    .relaxation_osc_power_down_o(po[4]));
  pmrs_core_model i_core (.mclk_i(mclk_i), .core_reset_i(core_reset_o), .req_i(req),
    .wait_instr_o(wait_instr_i), .stop_instr_o(stop_instr_i), .ext_standby_clk_o(ext_standby_clk_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] st();
    return {13'h0000, m_pwr[3:0] == 4'hF, 2'(m_mode)};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, e);
    @(posedge mclk_i);
  endtask
  // cycles until the core runs, within a small window of the expected count
  task automatic boot(input int e);
    for (n = 0; n < 400 && core_reset_o !== 1'b0; n++)
      @(posedge mclk_i);
    chk(16'(n), 16'((n > e - 8 && n < e + 8) ? n : e));
    {m_mode, m_pwr, m_sd} = '0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic acc();
    {pe, cc} = '0;
    repeat (8)
    begin
      @(negedge mclk_i);
      pe = pe | periph_clk_en_o;
      cc = cc | core_clk_en_o | mem_clk_en_o;
    end
  endtask
  initial
  begin
    #2_000_000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    boot(227);
    chk(16'(jtag_reset_o), 16'h0000);
    for (n = 0; n < 1100 && watchdog_tick_o !== 1'b1; n++)
      @(negedge mclk_i);
    @(negedge mclk_i);
    for (n = 1; n < 1100 && watchdog_tick_o !== 1'b1; n++)
      @(negedge mclk_i);
    chk(16'(n), 16'd1024);
    // ten frozen cycles stretch the watchdog period by ten
    @(posedge mclk_i);
    ce_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    ce_i <= 1'b1;
    for (n = 10; n < 1100 && watchdog_tick_o !== 1'b1; n++)
      @(negedge mclk_i);
    chk(16'(n), 16'(WDOG_DIV + 10));
    rdc(4'hF, 16'h0000);
    rnd  = lfsr(rnd);
    m_sd = (rnd[7:0] | 8'h01) & 8'h7F;
    wr(STOP_DISABLE_OFS, {8'h00, m_sd});
    rdc(STOP_DISABLE_OFS, {8'h00, m_sd});
    wr(POWER_CONFIG_OFS, 16'h0040);
    acc();
    chk({6'h00, master_clk_en_o, cc, pe}, 16'h03FF);
    chk(16'(hs_clk_en_o), 16'h0001);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 3)
      begin
        wr(POWER_CONFIG_OFS, 16'h000F);
        m_pwr = 7'h0F;
      end
      m_mode = (k < 2) ? 1 : 2;
      @(posedge mclk_i);
      req <= 2'(m_mode);
      @(posedge mclk_i);
      req <= 2'd0;
      repeat (4) @(posedge mclk_i);
      acc();
      chk({6'h00, master_clk_en_o, cc, pe}, {8'h02, k < 2 ? 8'hFF : m_sd});
      chk(16'(po), {12'h000, m_pwr[3:0]});
      rdc(STATUS_OFS, st());
      if (k == 2)
      begin
        irq_periph_i <= ~m_sd;
        repeat (4) @(posedge mclk_i);
        rdc(STATUS_OFS, st());
      end
      irq_any_i         <= (k == 0);
      debug_entry_i     <= (k == 1 || k == 4);
      irq_periph_i      <= (k == 2) ? m_sd : 8'h00;
      low_voltage_irq_i <= (k == 3);
      repeat (4) @(posedge mclk_i);
      m_mode = 0;
      rdc(STATUS_OFS, st());
      {irq_any_i, debug_entry_i, low_voltage_irq_i, irq_periph_i} <= 11'h000;
    end
    // standby system clock from the external clock: one tick per 200kHz period
    wr(POWER_CONFIG_OFS, 16'h002F);
    repeat (4) @(posedge mclk_i);
    for (n = 0; n < 300 && core_clk_en_o !== 1'b1; n++)
      @(negedge mclk_i);
    @(negedge mclk_i);
    for (n = 1; n < 300 && core_clk_en_o !== 1'b1; n++)
      @(negedge mclk_i);
    chk(16'(n), 16'(MCLK_HZ / 200_000));
    wr(POWER_CONFIG_OFS, 16'h001F);
    m_pwr  = 7'h1F;
    m_mode = 3;
    rdc(STATUS_OFS, st());
    chk(16'(po), 16'h001F);
    wd_to <= 1'b1;
    repeat (8) @(negedge mclk_i);
    chk(16'({master_clk_en_o, clock_generator_reset_o}), 16'h0000);
    @(posedge mclk_i);
    {wd_to, ext_reset_n_i} <= 2'b00;
    repeat (8) @(posedge mclk_i);
    ext_reset_n_i <= 1'b1;
    boot(163);
    wd_lor <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wd_lor <= 1'b0;
    repeat (80) @(negedge mclk_i);
    chk(16'({clock_generator_reset_o, peripheral_reset_o}), 16'h0001);
    @(posedge mclk_i);
    wd_to <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(16'({clock_generator_reset_o, peripheral_reset_o}), 16'h0003);
    @(posedge mclk_i);
    wd_to <= 1'b0;
    boot(161);
    wr(INTEGRATION_CONTROL_OFS, 16'h0001);
    repeat (4) @(negedge mclk_i);
    chk(16'({clock_generator_reset_o, sync_reset_o}), 16'h0003);
    boot(159);
    chk(16'(jtag_reset_o), 16'h0000);
    tally_and_finish();
  end
endmodule
